// ==== design/asr_pkg.sv ====
/*
  Package for the converter readout slice: register offsets, field positions,
  reset values and sizes.
  Assumes an APB slave port on the bus clock and a 12-bit converter result.
*/
package asr_pkg;
  // ---------------------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_GD_LOW     = 8'h00;
  localparam logic [7:0] OFS_GD_HIGH    = 8'h04;
  localparam logic [7:0] OFS_RES_LOW    = 8'h08;
  localparam logic [7:0] OFS_RES_HIGH   = 8'h0c;
  localparam logic [7:0] OFS_FIFO_DATA  = 8'h10;
  localparam logic [7:0] OFS_FIFO_STAT  = 8'h14;
  localparam logic [7:0] OFS_INT_STAT   = 8'h18;
  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int BIT_CALIBRATE   = 7;
  localparam int BIT_SAMPLE      = 6;
  localparam int BIT_BUSY        = 5;
  localparam int BIT_VALID       = 4;
  localparam int BIT_FIFO_EMPTY  = 2;
  localparam int BIT_INT_VALID   = 3;
  // ---------------------------------------------------------------------------
  // sizes and reset values
  // ---------------------------------------------------------------------------
  localparam int RESULT_W        = 12;
  localparam int GD_W            = 10;
  localparam int SAMPLE_W        = 16;
  localparam int FIFO_DEPTH      = 16;
  localparam logic [9:0] GD_RST  = 10'h000;
  localparam logic [9:0] GD_CFG_ALL = 10'h3ff;
endpackage : asr_pkg

// ==== design/asr_readout.sv ====
/*
  Readout slice: gate driver enables, converter status bytes, read fifo data
  port with 8/16-bit bus modes, and a sticky new-result flag.
  Assumes the analog block signals are asynchronous to pclk and are
  synchronised here; APB master is on pclk.
*/
`timescale 1ns/1ps

// -----------------------------------------------------------------------------
// fifo
// -----------------------------------------------------------------------------
module asr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0]   count;
  } asr_fifo_state_type;
  asr_fifo_state_type st_ff, nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             doWr;
  logic             doRd;

  assign inReady  = (st_ff.count != (AW+1)'(DEPTH));
  assign outValid = (st_ff.count != '0);
  assign outData  = mem[st_ff.rdPtr];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  always_comb begin
    nxt_st = st_ff;
    if (doWr) begin
      nxt_st.wrPtr = (st_ff.wrPtr == AW'(DEPTH-1)) ? '0 : st_ff.wrPtr + 1'b1;
    end
    if (doRd) begin
      nxt_st.rdPtr = (st_ff.rdPtr == AW'(DEPTH-1)) ? '0 : st_ff.rdPtr + 1'b1;
    end
    nxt_st.count = st_ff.count + (AW+1)'(doWr) - (AW+1)'(doRd);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[st_ff.wrPtr] <= inData;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  chk_fifo_count_cap: assert property (@(posedge clk) disable iff (rst)
    st_ff.count <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
  chk_fifo_full_hold: assert property (@(posedge clk) disable iff (rst)
    !inReady && inValid
    |=> $stable(st_ff.wrPtr))
    else $error("fifo written while full");
endmodule : asr_fifo

module asr_readout
  import asr_pkg::*;
#(
  parameter logic [9:0] GD_CFG   = GD_CFG_ALL,
  parameter bit         BUS16    = 1'b0,
  parameter int         FIFO_DEP = FIFO_DEPTH
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [15:0]          pwdata,
  output logic      [15:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic      [GD_W-1:0]      gateDriverOn,
  input  wire logic [RESULT_W-1:0]  analogResult,
  input  wire logic                 analogCalibrate,
  input  wire logic                 analogSample,
  input  wire logic                 analogBusy,
  input  wire logic                 resultValidFlag,
  output logic                      fifoInReady,
  output logic                      newResult
);
  typedef struct packed {
    logic [GD_W-1:0]     gd;
    logic [GD_W-1:0]     gdOut;
    logic [RESULT_W-1:0] res1;
    logic [RESULT_W-1:0] res2;
    logic [3:0]          flg1;
    logic [3:0]          flg2;
    logic                vldPrev;
    logic                newRes;
    logic                hiPhase;
    logic [15:0]         rdData;
    logic                ready;
    logic                err;
    logic                inReady;
  } asr_state_type;

  asr_state_type st_ff, nxt_st;
  logic [SAMPLE_W-1:0] fifoOut;
  logic                fifoValid;
  logic                fifoPop;
  logic                fifoPush;
  logic                fifoReady;
  logic                setup;
  logic                rdAcc;
  logic                wrAcc;
  logic [15:0]         rdMux;

  function automatic logic is_mapped(input logic [7:0] a);
    return a inside {OFS_GD_LOW, OFS_GD_HIGH, OFS_RES_LOW, OFS_RES_HIGH,
                     OFS_FIFO_DATA, OFS_FIFO_STAT, OFS_INT_STAT};
  endfunction : is_mapped

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  assign setup = psel && !penable;
  assign rdAcc = setup && !pwrite;
  assign wrAcc = setup && pwrite;

  // push on valid rising edge (synchronised)
  assign fifoPush = st_ff.flg2[0] && !st_ff.vldPrev;
  assign fifoPop  = rdAcc && (paddr == OFS_FIFO_DATA) && fifoValid
                    && (BUS16 || st_ff.hiPhase);

  asr_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEP)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inData   (SAMPLE_W'(st_ff.res2)),
    .inValid  (fifoPush),
    .inReady  (fifoReady),
    .outData  (fifoOut),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  // ---------------------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------------------
  always_comb begin
    rdMux = '0;
    unique case (paddr)
      OFS_GD_LOW:    rdMux[7:0] = st_ff.gd[7:0];
      OFS_GD_HIGH:   rdMux[1:0] = st_ff.gd[9:8];
      OFS_RES_LOW:   rdMux[7:0] = st_ff.res2[7:0];
      OFS_RES_HIGH:  rdMux[7:0] = {st_ff.flg2[3], st_ff.flg2[2], st_ff.flg2[1],
                                   st_ff.flg2[0], st_ff.res2[11:8]};
      OFS_FIFO_DATA: begin
        if (BUS16) begin
          rdMux = fifoOut;
        end else begin
          rdMux[7:0] = st_ff.hiPhase ? fifoOut[15:8] : fifoOut[7:0];
        end
      end
      OFS_FIFO_STAT: rdMux[BIT_FIFO_EMPTY] = !fifoValid;
      OFS_INT_STAT:  rdMux[BIT_INT_VALID] = st_ff.newRes;
      default:       rdMux = '0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.res1    = analogResult;
    nxt_st.res2    = st_ff.res1;
    nxt_st.flg1    = {analogCalibrate, analogSample, analogBusy, resultValidFlag};
    nxt_st.flg2    = st_ff.flg1;
    nxt_st.vldPrev = st_ff.flg2[0];
    nxt_st.ready   = setup;
    nxt_st.err     = setup && !is_mapped(paddr);
    nxt_st.inReady = fifoReady;
    if (setup) begin
      nxt_st.rdData = pwrite ? 16'h0000 : rdMux;
    end
    // only the gate bytes take writes
    if (wrAcc && paddr == OFS_GD_LOW) begin
      nxt_st.gd[7:0] = pwdata[7:0];
    end
    if (wrAcc && paddr == OFS_GD_HIGH) begin
      nxt_st.gd[9:8] = pwdata[1:0];
    end
    if (rdAcc && paddr == OFS_FIFO_DATA && fifoValid && !BUS16) begin
      nxt_st.hiPhase = !st_ff.hiPhase;
    end
    // set wins over clear
    if (rdAcc && paddr == OFS_INT_STAT) begin
      nxt_st.newRes = 1'b0;
    end
    if (fifoPush) begin
      nxt_st.newRes = 1'b1;
    end
    nxt_st.gdOut = nxt_st.gd & GD_CFG;
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff       <= '0;
      st_ff.gd    <= GD_RST;
      st_ff.gdOut <= GD_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign gateDriverOn = st_ff.gdOut;
  assign prdata      = st_ff.rdData;
  assign pready      = st_ff.ready;
  assign pslverr     = st_ff.err;
  assign fifoInReady = st_ff.inReady;
  assign newResult   = st_ff.newRes;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  chk_gate_low_drive: assert property (@(posedge clk) disable iff (rst)
    wrAcc && paddr == OFS_GD_LOW |=> gateDriverOn[7:0] == ($past(pwdata[7:0]) & GD_CFG[7:0]))
    else $error("gate low byte not driven");
  chk_gate_cfg_mask: assert property (@(posedge clk) disable iff (rst)
    (gateDriverOn & ~GD_CFG) == '0) else $error("unused gate bit set");
  chk_gate_high_drive: assert property (@(posedge clk) disable iff (rst)
    wrAcc && paddr == OFS_GD_HIGH |=> gateDriverOn[9:8] == ($past(pwdata[1:0]) & GD_CFG[9:8]))
    else $error("gate high bits not driven");
  chk_res_low_read: assert property (@(posedge clk) disable iff (rst)
    rdAcc && paddr == OFS_RES_LOW |=> prdata == {8'h00, $past(st_ff.res2[7:0])})
    else $error("result low byte wrong");
  chk_res_high_read: assert property (@(posedge clk) disable iff (rst)
    rdAcc && paddr == OFS_RES_HIGH |=> prdata[3:0] == $past(st_ff.res2[11:8])
      && prdata[7:4] == $past(st_ff.flg2)) else $error("status high byte wrong");
  chk_empty_flag: assert property (@(posedge clk) disable iff (rst)
    rdAcc && paddr == OFS_FIFO_STAT |=> prdata[BIT_FIFO_EMPTY] == !$past(fifoValid))
    else $error("empty flag wrong");
  chk_byte_pop: assert property (@(posedge clk) disable iff (rst)
    fifoPop |-> (BUS16 || st_ff.hiPhase)) else $error("pop on low byte");
  chk_new_result: assert property (@(posedge clk) disable iff (rst)
    fifoPush |=> newResult) else $error("new result not flagged");
  chk_ro_write: assert property (@(posedge clk) disable iff (rst)
    wrAcc && paddr != OFS_GD_LOW && paddr != OFS_GD_HIGH |=> $stable(gateDriverOn))
    else $error("write altered state");
  chk_data16_read: assert property (@(posedge clk) disable iff (rst)
    BUS16 && rdAcc && paddr == OFS_FIFO_DATA |=> prdata == $past(fifoOut))
    else $error("16-bit data wrong");
  chk_hi_phase_toggle: assert property (@(posedge clk) disable iff (rst)
    !BUS16 && rdAcc && paddr == OFS_FIFO_DATA && fifoValid
    |=> st_ff.hiPhase != $past(st_ff.hiPhase))
    else $error("byte phase did not advance");
  chk_low_byte_first: assert property (@(posedge clk) disable iff (rst)
    !BUS16 && rdAcc && paddr == OFS_FIFO_DATA && !st_ff.hiPhase
    |=> prdata == {8'h00, $past(fifoOut[7:0])})
    else $error("low byte not returned first");
  chk_high_byte_second: assert property (@(posedge clk) disable iff (rst)
    !BUS16 && rdAcc && paddr == OFS_FIFO_DATA && st_ff.hiPhase
    |=> prdata == {8'h00, $past(fifoOut[15:8])})
    else $error("high byte not returned second");
  chk_narrow_upper_zero: assert property (@(posedge clk) disable iff (rst)
    !BUS16 && rdAcc
    |=> prdata[15:8] == 8'h00)
    else $error("upper read byte driven in 8-bit mode");
  chk_wide_pop_each: assert property (@(posedge clk) disable iff (rst)
    BUS16 && rdAcc && paddr == OFS_FIFO_DATA && fifoValid
    |-> fifoPop)
    else $error("16-bit read did not pop");
  chk_gate_reserved: assert property (@(posedge clk) disable iff (rst)
    rdAcc && paddr == OFS_GD_HIGH
    |=> prdata[15:2] == 14'h0000)
    else $error("reserved gate bits read nonzero");
  chk_clear_on_read: assert property (@(posedge clk) disable iff (rst)
    rdAcc && paddr == OFS_INT_STAT && !fifoPush
    |=> !newResult)
    else $error("new result not cleared by read");
  chk_int_write_keep: assert property (@(posedge clk) disable iff (rst)
    wrAcc && paddr == OFS_INT_STAT && newResult
    |=> newResult)
    else $error("write cleared new result");
  chk_ready_pulse: assert property (@(posedge clk) disable iff (rst)
    setup
    |=> pready ##1 !pready)
    else $error("ready not a single access cycle");
  chk_err_unmapped: assert property (@(posedge clk) disable iff (rst)
    setup && !is_mapped(paddr)
    |=> pslverr)
    else $error("unmapped access without error");
  cov_hiphase: cover property (@(posedge clk) disable iff (rst) st_ff.hiPhase);
  cov_push:  cover property (@(posedge clk) disable iff (rst) fifoPush);
  cov_pop:   cover property (@(posedge clk) disable iff (rst) fifoPop);
  cov_full:  cover property (@(posedge clk) disable iff (rst) !fifoReady);
  cov_gdwr:  cover property (@(posedge clk) disable iff (rst) wrAcc && paddr == OFS_GD_HIGH);
endmodule : asr_readout

// ==== testbench/asr_apb_master.sv ====
/*
  Bus master model for the converter readout slice: one xfer task that runs
  an APB setup and access phase and returns read data and error.
  Assumes the slave answers within 16 cycles; signals change at falling edges.
*/
`timescale 1ns/1ps
module asr_apb_master (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [15:0]      pwdata,
  input  wire logic [15:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 16'h0000;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] wd,
                      output logic [15:0] rd, output logic err);
    int n;
    n = 0;
    @(negedge clk);
    psel   = 1'b1;
    pwrite = wr;
    paddr  = a;
    pwdata = wd;
    @(negedge clk);
    penable = 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!pready && n < 16);
    rd  = prdata;
    err = pslverr || !pready;
    // released bus shows no stale address or data
    @(negedge clk);
    psel    = 1'b0;
    penable = 1'b0;
    paddr   = ~a;
    pwdata  = ~wd;
  endtask : xfer
endmodule : asr_apb_master

// ==== testbench/tb.sv ====
/*
  Self-checking bench for the readout slice: an 8-bit instance with a partial
  gate mask and a 16-bit instance with the full mask share one bus master.
  Assumes offsets and flag positions of asr_pkg.
*/
`timescale 1ns/1ps
module tb;
  import asr_pkg::*;
  localparam logic [9:0] CFG_A = 10'h2f3;
  logic clk = 1'b0, rst = 1'b1, err, pready, pslverr, pready16, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [15:0] pwdata, prdata, prdata16, rd, rd16;
  logic [9:0] gd, gd16;
  logic [11:0] aRes = 12'h000;
  logic aCal = 1'b0, aSmp = 1'b0, aBusy = 1'b0, aVal = 1'b0, fifoInReady, newResult;
  logic [11:0] expQ [$];
  int miscompares = 0, numChecks = 0;
  logic [9:0] gdRows [4] = '{10'h000, 10'h3ff, 10'h2a5, 10'h15a};
  logic [15:0] stRows [5] = '{16'h8abc, 16'h4123, 16'h2fed, 16'h1555, 16'hf000};
  always #2 clk = ~clk;
  always @(posedge clk) if (pready16) rd16 <= prdata16;
  asr_apb_master i_asr_apb_master (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  asr_readout #(.GD_CFG(CFG_A)) i_asr_readout (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gateDriverOn(gd), .analogResult(aRes),
    .analogCalibrate(aCal), .analogSample(aSmp), .analogBusy(aBusy), .resultValidFlag(aVal),
    .fifoInReady(fifoInReady), .newResult(newResult));
  asr_readout #(.BUS16(1'b1)) i_asr_readout_w16 (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata16),
    .pready(pready16), .pslverr(), .gateDriverOn(gd16), .analogResult(aRes),
    .analogCalibrate(aCal), .analogSample(aSmp), .analogBusy(aBusy), .resultValidFlag(aVal),
    .fifoInReady(), .newResult());
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    if (miscompares == 0 && numChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] wd);
    i_asr_apb_master.xfer(wr, a, wd, rd, err);
  endtask : apb
  task automatic push(input logic [11:0] v, input bit keep);
    @(negedge clk);
    aRes = v;
    aVal = 1'b1;
    if (keep) expQ.push_back(v);
    repeat (4) @(negedge clk);
    aVal = 1'b0;
    repeat (4) @(negedge clk);
  endtask : push
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    check("gdReset", {6'h00, gd}, 16'h0000);
    check("newReset", {15'h0, newResult}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFS_GD_LOW, {8'h00, gdRows[i][7:0]});
      apb(1'b1, OFS_GD_HIGH, {8'h00, 6'h3f, gdRows[i][9:8]});
      check("gdMasked", {6'h00, gd}, {6'h00, gdRows[i] & CFG_A});
      check("gdFull", {6'h00, gd16}, {6'h00, gdRows[i]});
    end
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      if (stRows[i][12] && !aVal) expQ.push_back(stRows[i][11:0]);
      {aCal, aSmp, aBusy, aVal, aRes} = stRows[i];
      repeat (4) @(negedge clk);
      apb(1'b0, OFS_RES_LOW, 16'h0000);
      check("resLow", {8'h00, rd[7:0]}, {8'h00, stRows[i][7:0]});
      apb(1'b1, OFS_RES_HIGH, 16'hffff);
      apb(1'b0, OFS_RES_HIGH, 16'h0000);
      check("resHigh", {8'h00, rd[7:0]}, {8'h00, stRows[i][15:8]});
    end
    aVal = 1'b0;
    // ---------------------------------------------------------------------------
    // fifo fill until refused, then drain byte-wise
    // ---------------------------------------------------------------------------
    apb(1'b1, OFS_INT_STAT, 16'hffff);
    check("newKeep", {15'h0, newResult}, 16'h0001);
    apb(1'b0, OFS_INT_STAT, 16'h0000);
    check("newClear", {15'h0, newResult}, 16'h0000);
    for (int n = 0; expQ.size() < FIFO_DEPTH; n++) push(12'h5a3 + 12'h111 * n[11:0], 1'b1);
    check("newSet", {15'h0, newResult}, 16'h0001);
    check("fullRefuse", {15'h0, fifoInReady}, 16'h0000);
    push(12'h777, 1'b0);
    apb(1'b0, OFS_FIFO_STAT, 16'h0000);
    check("notEmpty", {15'h0, rd[BIT_FIFO_EMPTY]}, 16'h0000);
    for (int k = 0; k < 32; k++) begin
      if (k == 31) begin
        apb(1'b0, OFS_FIFO_STAT, 16'h0000);
        check("emptyEarly", {15'h0, rd[BIT_FIFO_EMPTY]}, 16'h0000);
      end
      apb(1'b0, OFS_FIFO_DATA, 16'h0000);
      if (k % 2 == 0) check("fifoLow", {8'h00, rd[7:0]}, {8'h00, expQ[k/2][7:0]});
      else check("fifoHigh", {8'h00, rd[7:0]}, {12'h000, expQ[k/2][11:8]});
      if (k < 16) check("fifoWord", {4'h0, rd16[11:0]}, {4'h0, expQ[k]});
    end
    apb(1'b1, OFS_FIFO_DATA, 16'h5a5a);
    apb(1'b1, OFS_FIFO_STAT, 16'h0000);
    apb(1'b0, OFS_FIFO_STAT, 16'h0000);
    check("emptyNow", {15'h0, rd[BIT_FIFO_EMPTY]}, 16'h0001);
    check("emptyWide", {15'h0, rd16[BIT_FIFO_EMPTY]}, 16'h0001);
    apb(1'b0, 8'h40, 16'h0000);
    check("unmappedErr", {15'h0, err}, 16'h0001);
    check("unmappedData", rd, 16'h0000);
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    check("gdReset2", {6'h00, gd16}, 16'h0000);
    end_of_test();
  end
endmodule : tb
